/* verilog/vcs_defs.svh */
`ifndef VCS_DEFS_SVH
`define VCS_DEFS_SVH

// APB byte offsets
`define VCS_APB_ADC       8'h00
`define VCS_APB_DAC       8'h04
`define VCS_APB_STATUS    8'h08
`define VCS_APB_CREG_BASE 8'h20

// Serial frame layout
`define VCS_FRAME_BITS    9'h100
`define VCS_SEC_START     8'h80
`define VCS_SEC_DATA      8'h88
`define VCS_SEC_LAST      8'h8F
`define VCS_PRI_LAST      8'h0F
`define VCS_MODE1_PRI     8'hFF
`define VCS_MODE1_SEC     8'h7F

// Codec register numbers and fields
`define VCS_REG_N1        3'h3
`define VCS_REG_M1        3'h4
`define VCS_REG_RXG1      3'h5
`define VCS_REG_ADCVOL    3'h6
`define VCS_REG_DACVOL    3'h7
`define VCS_RST_ADCVOL    8'h5C
`define VCS_RST_DACVOL    8'hB8
`define VCS_ADCVOL_GAIN   6:2
`define VCS_DACVOL_GAIN   7:3
`define VCS_BIT_LINE_MUTE 1
`define VCS_BIT_LEFT_MUTE 2
`define VCS_BIT_RIGHT_MUTE 1
`define VCS_LINE_IN_GAIN  7:6
`define VCS_MIC_GAIN      4:3

// Bit clock: half periods per master clock are (M1+1)/(10*(N1+1)), capped at 1, and 1 in bypass
`define VCS_HALF_DIV      4'hA
// Zero crossing timeout in frames
`define VCS_ZC_FRAMES     9'h100

`endif

/* verilog/vcs_pkg.sv */
package vcs_pkg;

   typedef enum logic [1:0] {VCS_MODE_FRAMED, VCS_MODE_PULSE, VCS_MODE_SLAVE, VCS_MODE_RSVD} vcs_mode_e;
   typedef logic [7:0] vcs_byte_t;

   // Digital gain, code 0 is -34.5 dB, code 23 is 0 dB, code 31 is +12 dB
   function automatic logic [15:0] vcs_gain(input logic [15:0] x, input logic [4:0] code);
      logic [5:0]         e;
      logic [9:0]         mant;
      logic signed [25:0] p;
      logic signed [25:0] s;
      e    = {1'b0, code} + 6'h01;
      case (e[1:0])
         2'h0:    mant = 10'h100;
         2'h1:    mant = 10'h130;
         2'h2:    mant = 10'h16A;
         default: mant = 10'h1AF;
      endcase
      p = 26'($signed(x)) * 26'($signed(mant));
      s = p >>> (5'h0E - {1'b0, e[5:2]});
      if (s > 26'sh0007FFF)       return 16'h7FFF;
      else if (s < -26'sh0008000) return 16'h8000;
      else                        return s[15:0];
   endfunction

endpackage

/* verilog/vcs_serial_port.sv */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "vcs_defs.svh"

module vcs_serial_port
   import vcs_pkg::*;
(
   input  wire logic        mclk_i,             // 200 MHz system clock
   input  wire logic        rst_i,              // Async reset, active high
   input  wire logic        codec_reset_n_i,    // Codec reset pin
   input  wire logic        master_clock_in_i,  // Master clock pin
   input  wire logic        bit_clock_i,        // Bit clock pin level
   output logic             bit_clock_o,        // Bit clock drive
   output logic             bit_clock_oe_n_o,   // Bit clock enable, low drives
   input  wire logic        frame_sync_i,       // Frame sync pin level
   output logic             frame_sync_o,       // Frame sync drive, active low
   output logic             frame_sync_oe_n_o,  // Frame sync enable, low drives
   input  wire logic        serial_in_i,        // Serial data from DSP
   input  wire logic        serial_out_i,       // Serial out pin level
   output logic             serial_out_o,       // Serial data to DSP
   output logic             serial_out_oe_n_o,  // Serial out enable, low drives
   output logic [15:0]      line_output_o,      // Line output sample
   output logic [15:0]      left_speaker_out_o, // Left speaker sample
   output logic [15:0]      right_speaker_out_o,// Right speaker sample
   output logic [1:0]       mic_gain_o,         // Microphone preamp gain code
   output logic [1:0]       line_in_gain_o,     // Line input gain code
   output logic             pll_bypass_o,       // Both dividers zero
   input  wire logic        psel,               // APB select
   input  wire logic        penable,            // APB enable
   input  wire logic        pwrite,             // APB direction
   input  wire logic [7:0]  paddr,              // APB byte address
   input  wire logic [31:0] pwdata,             // APB write data
   output logic [31:0]      prdata,             // APB read data
   output logic             pready,             // APB ready
   output logic             pslverr             // APB error
);

   // Pin synchronisers: 0 mclk, 1 frame_sync, 2 sdata, 3 sdo strap, 4 sclk strap, 5 reset
   logic [5:0] sy1_q;
   logic [5:0] sy2_q;
   logic       mc3_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sy1_q <= 6'h00;
         sy2_q <= 6'h00;
         mc3_q <= 1'b0;
      end else begin
         sy1_q <= {codec_reset_n_i, bit_clock_i, serial_out_i, serial_in_i, frame_sync_i, master_clock_in_i};
         sy2_q <= sy1_q;
         mc3_q <= sy2_q[0];
      end
   end

   logic mc_rise;
   logic mc_fall;
   assign mc_rise = sy2_q[0] & ~mc3_q;
   assign mc_fall = ~sy2_q[0] & mc3_q;

   // Mode straps, pins are released while codec reset is low
   vcs_mode_e mode_q;
   logic      strap_ok_q;
   logic      strap_arm_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q      <= VCS_MODE_FRAMED;
         strap_ok_q  <= 1'b0;
         strap_arm_q <= 1'b1;
      end else if (!sy2_q[5]) begin
         if (strap_arm_q && mc_rise) begin
            mode_q      <= vcs_mode_e'(sy2_q[4:3]);
            strap_ok_q  <= 1'b1;
            strap_arm_q <= 1'b0;
         end
      end else begin
         strap_arm_q <= 1'b1;
      end
   end

   logic running;
   logic slave;
   assign running = sy2_q[5] & strap_ok_q & (mode_q != VCS_MODE_RSVD);
   assign slave   = (mode_q == VCS_MODE_SLAVE);

   // Codec registers 1..7, register 0 reads as zero
   vcs_byte_t creg_q [8];
   logic      creg_we;
   logic [2:0] creg_wa;
   vcs_byte_t creg_wd;

   // Bit clock generator, fractional divider on master clock rises
   logic [11:0] acc_q;
   logic        bclk_q;
   logic        g_rise_q;
   logic        g_fall_q;
   logic [11:0] thr;
   logic        bypass;
   assign bypass = (creg_q[`VCS_REG_N1] == 8'h00) && (creg_q[`VCS_REG_M1] == 8'h00);
   assign thr    = 12'(`VCS_HALF_DIV * ({4'h0, creg_q[`VCS_REG_N1]} + 12'h001));
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q    <= 12'h000;
         bclk_q   <= 1'b0;
         g_rise_q <= 1'b0;
         g_fall_q <= 1'b0;
      end else begin
         g_rise_q <= 1'b0;
         g_fall_q <= 1'b0;
         if (!running || slave) begin
            acc_q  <= 12'h000;
            bclk_q <= 1'b0;
         end else if (mc_rise) begin
            // Bypass halves the master clock; at most one toggle per master edge
            if (bypass || (acc_q + {3'h0, creg_q[`VCS_REG_M1]} + 12'h001 >= thr)) begin
               acc_q    <= bypass ? 12'h000 : 12'(acc_q + {3'h0, creg_q[`VCS_REG_M1]} + 12'h001 - thr);
               bclk_q   <= ~bclk_q;
               g_rise_q <= ~bclk_q;
               g_fall_q <= bclk_q;
            end else begin
               acc_q <= 12'(acc_q + {3'h0, creg_q[`VCS_REG_M1]} + 12'h001);
            end
         end
      end
   end

   // Slave bit timing is the master clock itself
   logic ev_rise;
   logic ev_fall;
   assign ev_rise = running & (slave ? mc_rise : g_rise_q);
   assign ev_fall = running & (slave ? mc_fall : g_fall_q);

   // Bit position within the 256-bit frame
   logic [7:0] bit_q;
   logic       framed_q;
   logic       fs_prev_q;
   logic       start_pend_q;
   logic [7:0] nb;
   assign nb = (slave && start_pend_q) ? 8'h00 : 8'(bit_q + 8'h01);
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_q        <= 8'hFF;
         framed_q     <= 1'b0;
         fs_prev_q    <= 1'b1;
         start_pend_q <= 1'b0;
      end else if (!running) begin
         bit_q        <= 8'hFF;
         framed_q     <= 1'b0;
         fs_prev_q    <= 1'b1;
         start_pend_q <= 1'b0;
      end else begin
         if (slave && ev_fall) begin
            fs_prev_q <= sy2_q[1];
            if (!sy2_q[1] && fs_prev_q) start_pend_q <= 1'b1;
         end
         if (ev_rise) begin
            bit_q <= nb;
            if (!slave || start_pend_q) framed_q <= 1'b1;
            start_pend_q <= 1'b0;
         end
      end
   end

   // Slot decode, secondary sits in the middle of the frame
   function automatic logic in_slot(input logic [7:0] b, input logic sec, input logic fr);
      return fr && ((b <= `VCS_PRI_LAST) || (sec && b >= `VCS_SEC_START && b <= `VCS_SEC_LAST));
   endfunction

   // Receive shifter and secondary frame decode
   logic [15:0] rx_q;
   logic [15:0] rx_next;
   logic        sec_q;
   logic        rw_q;
   logic [4:0]  addr_q;
   logic [15:0] dac_raw_q;
   assign rx_next = {rx_q[14:0], sy2_q[2]};
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_q      <= 16'h0000;
         sec_q     <= 1'b0;
         rw_q      <= 1'b0;
         addr_q    <= 5'h00;
         dac_raw_q <= 16'h0000;
      end else if (!running) begin
         sec_q <= 1'b0;
      end else if (ev_fall && in_slot(bit_q, sec_q, framed_q)) begin
         rx_q <= rx_next;
         if (bit_q == `VCS_PRI_LAST) begin
            dac_raw_q <= {rx_next[15:1], 1'b0};
            sec_q     <= rx_next[0];
         end
         if (bit_q == 8'(`VCS_SEC_DATA - 8'h01)) begin
            rw_q   <= rx_next[7];
            addr_q <= rx_next[4:0];
         end
         if (bit_q == `VCS_SEC_LAST) sec_q <= 1'b0;
      end
   end

   // One write per secondary frame, into the implemented register range
   assign creg_we = ev_fall && framed_q && sec_q && (bit_q == `VCS_SEC_LAST) && !rw_q
                    && (addr_q[4:3] == 2'h0) && (addr_q[2:0] != 3'h0);
   assign creg_wa = addr_q[2:0];
   assign creg_wd = rx_next[7:0];

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 8; i++) creg_q[i] <= 8'h00;
         creg_q[`VCS_REG_ADCVOL] <= `VCS_RST_ADCVOL;
         creg_q[`VCS_REG_DACVOL] <= `VCS_RST_DACVOL;
      end else if (creg_we) begin
         creg_q[creg_wa] <= creg_wd;
      end
   end

   logic [7:0] rd_byte;
   assign rd_byte = (addr_q[4:3] == 2'h0) ? creg_q[addr_q[2:0]] : 8'h00;

   // Gain stages: 0 is input (ADC) path, 1 is output (DAC) path
   logic [15:0] adc_raw_q;
   logic [15:0] adc_gain_q;
   logic [15:0] dac_gain_q;
   logic [4:0]  act_q [2];
   logic [8:0]  zc_cnt_q [2];
   logic [15:0] last_q [2];
   logic [4:0]  want [2];
   logic [15:0] smp [2];
   logic        frame_tick;
   assign frame_tick = ev_rise && framed_q && (nb == 8'h00);
   assign want[0] = creg_q[`VCS_REG_ADCVOL][`VCS_ADCVOL_GAIN];
   assign want[1] = creg_q[`VCS_REG_DACVOL][`VCS_DACVOL_GAIN];
   assign smp[0]  = adc_raw_q;
   assign smp[1]  = dac_raw_q;

   // Gain changes wait for a sign change, a zero sample or a 256-frame timeout so the step is inaudible
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 2; i++) begin
            act_q[i]    <= 5'h17;
            zc_cnt_q[i] <= 9'h000;
            last_q[i]   <= 16'h0000;
         end
      end else if (frame_tick) begin
         for (int i = 0; i < 2; i++) begin
            last_q[i] <= smp[i];
            if (want[i] == act_q[i]) begin
               zc_cnt_q[i] <= 9'h000;
            end else if ((smp[i][15] != last_q[i][15]) || (smp[i] == 16'h0000)
                         || (zc_cnt_q[i] == 9'(`VCS_ZC_FRAMES - 9'h001))) begin
               act_q[i]    <= want[i];
               zc_cnt_q[i] <= 9'h000;
            end else begin
               zc_cnt_q[i] <= 9'(zc_cnt_q[i] + 9'h001);
            end
         end
      end
   end

   // Converter side samples, refreshed once per frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         adc_gain_q          <= 16'h0000;
         dac_gain_q          <= 16'h0000;
         line_output_o       <= 16'h0000;
         left_speaker_out_o  <= 16'h0000;
         right_speaker_out_o <= 16'h0000;
      end else if (frame_tick) begin
         adc_gain_q          <= vcs_gain(adc_raw_q, act_q[0]);
         dac_gain_q          <= vcs_gain(dac_raw_q, act_q[1]);
         line_output_o       <= creg_q[`VCS_REG_ADCVOL][`VCS_BIT_LINE_MUTE] ? 16'h0000
                                : vcs_gain(dac_raw_q, act_q[1]);
         left_speaker_out_o  <= creg_q[`VCS_REG_DACVOL][`VCS_BIT_LEFT_MUTE] ? 16'h0000
                                : vcs_gain(dac_raw_q, act_q[1]);
         right_speaker_out_o <= creg_q[`VCS_REG_DACVOL][`VCS_BIT_RIGHT_MUTE] ? 16'h0000
                                : vcs_gain(dac_raw_q, act_q[1]);
      end
   end

   // Analog control levels
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mic_gain_o     <= 2'h0;
         line_in_gain_o <= 2'h0;
         pll_bypass_o   <= 1'b1;
      end else begin
         mic_gain_o     <= creg_q[`VCS_REG_RXG1][`VCS_MIC_GAIN];
         line_in_gain_o <= creg_q[`VCS_REG_RXG1][`VCS_LINE_IN_GAIN];
         pll_bypass_o   <= bypass;
      end
   end

   // Transmit word and pin drive, data and frame sync changes follow a bit clock rise
   logic [15:0] tx_q;
   logic [15:0] tx_w;
   logic [15:0] prim;
   assign prim = slave ? {adc_gain_q[15:1], 1'b0} : adc_gain_q;
   always_comb begin
      tx_w = tx_q;
      if (nb == 8'h00) tx_w = prim;
      else if (nb == `VCS_SEC_START) tx_w = 16'h0000;
      else if (nb == `VCS_SEC_DATA && rw_q) tx_w = {tx_q[15:8], rd_byte};
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_q              <= 16'h0000;
         serial_out_o      <= 1'b0;
         serial_out_oe_n_o <= 1'b1;
         frame_sync_o      <= 1'b1;
         frame_sync_oe_n_o <= 1'b1;
         bit_clock_o       <= 1'b0;
         bit_clock_oe_n_o  <= 1'b1;
      end else begin
         bit_clock_o       <= bclk_q;
         bit_clock_oe_n_o  <= !(running && !slave);
         frame_sync_oe_n_o <= !(running && !slave);
         if (!running) begin
            serial_out_oe_n_o <= 1'b1;
            frame_sync_o      <= 1'b1;
         end else if (ev_rise) begin
            tx_q              <= tx_w;
            serial_out_o      <= tx_w[~nb[3:0]];
            serial_out_oe_n_o <= !in_slot(nb, sec_q, framed_q || !slave || start_pend_q);
            if (mode_q == VCS_MODE_FRAMED)
               frame_sync_o <= !in_slot(nb, sec_q, 1'b1);
            else
               frame_sync_o <= !((nb == `VCS_MODE1_PRI) || (sec_q && nb == `VCS_MODE1_SEC));
         end
      end
   end

   // APB slave: decode in setup, answer registered in access phase
   logic [15:0] adc_raw_w;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata    <= 32'h00000000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         adc_raw_q <= 16'h0000;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            if (paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0) begin
               prdata  <= {24'h000000, creg_q[paddr[4:2]] & {8{paddr[4:2] != 3'h0}}};
               pslverr <= pwrite;
            end else if (paddr == `VCS_APB_ADC) begin
               prdata <= {16'h0000, adc_raw_q};
            end else if (paddr == `VCS_APB_DAC) begin
               prdata  <= {16'h0000, dac_gain_q};
               pslverr <= pwrite;
            end else if (paddr == `VCS_APB_STATUS) begin
               prdata  <= {16'h0000, bit_q, 3'h0, sec_q, framed_q, strap_ok_q, mode_q};
               pslverr <= pwrite;
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (psel && penable && pready && pwrite && paddr == `VCS_APB_ADC)
            adc_raw_q <= pwdata[15:0];
      end
   end

   // Checks
   chk_strap_mode: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!sy2_q[5] && strap_arm_q && mc_rise) |=> (strap_ok_q && mode_q == vcs_mode_e'($past(sy2_q[4:3]))))
      else $error("strap mode not captured");
   chk_slave_lsb_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      (slave && bit_q == `VCS_PRI_LAST && !serial_out_oe_n_o) |-> !serial_out_o)
      else $error("slave primary LSB not zero");
   chk_primary_every: assert property (@(posedge mclk_i) disable iff (rst_i)
      (running && framed_q && ev_rise && bit_q == 8'hFF && !slave) |=> !serial_out_oe_n_o)
      else $error("primary frame missing");
   chk_idle_slot_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      (bit_q > `VCS_PRI_LAST && bit_q < `VCS_SEC_START) |-> serial_out_oe_n_o)
      else $error("serial_out driven outside slots");
   chk_sec_midway: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!serial_out_oe_n_o && bit_q > `VCS_PRI_LAST) |-> (bit_q >= `VCS_SEC_START && bit_q <= `VCS_SEC_LAST))
      else $error("secondary frame misplaced");
   chk_bclk_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
      (running && !slave) |=> !bit_clock_oe_n_o)
      else $error("bit clock not driven in master mode");
   chk_reg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
      creg_we |=> creg_q[$past(creg_wa)] == $past(creg_wd))
      else $error("register write lost");
   chk_gain_timeout: assert property (@(posedge mclk_i) disable iff (rst_i)
      (frame_tick && want[0] != act_q[0] && zc_cnt_q[0] == 9'h0FF) |=> act_q[0] == $past(want[0]))
      else $error("gain not applied after timeout");
   chk_line_mute: assert property (@(posedge mclk_i) disable iff (rst_i)
      (frame_tick && creg_q[`VCS_REG_ADCVOL][`VCS_BIT_LINE_MUTE]) |=> line_output_o == 16'h0000)
      else $error("line output not muted");

endmodule // vcs_serial_port

/* verification/vcs_dsp_model.sv */
`timescale 1ns/1ps
// Behavioural DSP on the serial link, codec as bit clock master
module vcs_dsp_model (
   input  wire logic        bclk_i,   // Bit clock pin
   input  wire logic        fs_n_i,   // Frame sync pin, active low
   input  wire logic        sdo_i,    // Codec serial_out pin
   input  wire logic [15:0] pri_i,    // Primary word to send
   input  wire logic [15:0] sec_i,    // Secondary word to send
   output logic             sdi_o,    // Codec serial_in drive
   output logic [7:0]       pos_o,    // Bit index in the frame
   output logic [15:0]      rx_pri_o, // Last primary received
   output logic [15:0]      rx_sec_o  // Last secondary received
);
   logic        fs_q = 1'b1;
   logic [15:0] sh   = 16'h0000;
   logic [7:0]  n;
   initial pos_o = 8'h00;
   initial sdi_o = 1'b0;
   // Align on a sync fall, but the mid-frame window must not realign
   always @(negedge bclk_i) begin
      if (!fs_n_i && fs_q && pos_o != 8'h80)
         pos_o <= 8'h00;
      fs_q <= fs_n_i;
      if (!fs_n_i)
         sh <= {sh[14:0], sdo_i};
      if (!fs_n_i && pos_o == 8'h0F)
         rx_pri_o <= {sh[14:0], sdo_i};
      if (!fs_n_i && pos_o == 8'h8F)
         rx_sec_o <= {sh[14:0], sdo_i};
   end
   // Bit goes out at the rise, well ahead of the codec sample at the fall
   always @(posedge bclk_i) begin
      n = pos_o + 8'h01;
      pos_o <= n;
      if (n < 8'h10)
         sdi_o <= pri_i[4'hF - n[3:0]];
      else if (n >= 8'h80 && n < 8'h90 && pri_i[0])
         sdi_o <= sec_i[4'hF - n[3:0]];
      else
         sdi_o <= ~sdi_o; // Idle line toggles, never a stale bit
   end
endmodule // vcs_dsp_model

/* verification/vcs_serial_port_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module vcs_serial_port_test;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        crst_n = 1'b0;
   logic        mck = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] pri = 16'h1235;
   logic [15:0] sec = 16'h05D8;
   logic [31:0] rd;
   logic        er;
   int          n_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic        bclk_o, bclk_oe_n, fs_o, fs_oe_n, sdo_o, sdo_oe_n, serial_in, byp, pready, pslverr;
   logic [15:0] line, left, right, rx_pri, rx_sec;
   logic [1:0]  microphone_input, lig;
   logic [7:0]  pos;
   logic [31:0] prdata;
   logic [7:0]  ra [4] = '{8'h38, 8'h3C, 8'h34, 8'h20};
   logic [7:0]  re [4] = '{8'h5C, 8'hB8, 8'h00, 8'h00};
   // Pins resolved with pull-downs as straps for mode 0, frame sync pulled up
   wire bclk_pin = bclk_oe_n ? 1'b0 : bclk_o;
   wire sdo_pin  = sdo_oe_n ? 1'b0 : sdo_o;
   wire fs_pin   = fs_oe_n ? 1'b1 : fs_o;

   vcs_serial_port uut (.mclk_i(mclk_i), .rst_i(rst_i), .codec_reset_n_i(crst_n), .master_clock_in_i(mck),
      .bit_clock_i(bclk_pin), .bit_clock_o(bclk_o), .bit_clock_oe_n_o(bclk_oe_n), .frame_sync_i(fs_pin),
      .frame_sync_o(fs_o), .frame_sync_oe_n_o(fs_oe_n), .serial_in_i(serial_in), .serial_out_i(sdo_pin),
      .serial_out_o(sdo_o), .serial_out_oe_n_o(sdo_oe_n), .line_output_o(line), .left_speaker_out_o(left),
      .right_speaker_out_o(right), .mic_gain_o(microphone_input), .line_in_gain_o(lig), .pll_bypass_o(byp), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   vcs_dsp_model dsp (.bclk_i(bclk_pin), .fs_n_i(fs_pin), .sdo_i(sdo_pin), .pri_i(pri), .sec_i(sec),
      .sdi_o(serial_in), .pos_o(pos), .rx_pri_o(rx_pri), .rx_sec_o(rx_sec));

   // 200 MHz system clock and free-running 8 MHz master clock, unrelated
   initial forever #2.5 mclk_i = ~mclk_i;
   initial forever #62.5 mck = ~mck;
   // Hang guard, five frames need about 64000 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         finish_test;
      end
   end

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      `CHK("pready", 1'b1, pready)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
   endtask
   // Swap the secondary word once the current secondary window is over
   task automatic next_sec(input logic [15:0] w);
      wait (pos == 8'h91);
      sec = w;
      wait (pos != 8'h91);
   endtask

   initial begin
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (250) @(posedge mclk_i);
      crst_n <= 1'b1;
      `CHK("mic rst", 2'h0, microphone_input)
      `CHK("line in rst", 2'h0, lig)
      `CHK("line rst", 16'h0000, line)
      `CHK("right rst", 16'h0000, right)
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ra[i], 32'h0);
         `CHK("creg rd", re[i], rd[7:0])
      end
      apb(1'b0, 8'h08, 32'h0);
      `CHK("mode", 2'h0, rd[1:0])
      `CHK("bypass", 1'b1, byp)
      apb(1'b1, 8'h04, 32'h1);
      `CHK("ro write", 1'b1, er)
      apb(1'b0, 8'hC0, 32'h0);
      `CHK("unmapped", 1'b1, er)
      apb(1'b1, 8'h00, 32'h1234);
      `CHK("adc write", 1'b0, er)
      next_sec(16'h065E);
      next_sec(16'h07BC);
      next_sec(16'h8500);
      next_sec(16'h8500);
      `CHK("mic gain", 2'h3, microphone_input)
      `CHK("line gain", 2'h3, lig)
      `CHK("reg read", 8'hD8, rx_sec[7:0])
      `CHK("audio out", 16'h1234, rx_pri)
      `CHK("line mute", 16'h0000, line)
      `CHK("left mute", 16'h0000, left)
      `CHK("right out", 16'h1234, right)
      apb(1'b0, 8'h34, 32'h0);
      `CHK("reg5 apb", 8'hD8, rd[7:0])
      apb(1'b0, 8'h04, 32'h0);
      `CHK("dac apb", 16'h1234, rd[15:0])
      finish_test;
   end
endmodule // vcs_serial_port_test
